// ### reset_guard_params.svh
`ifndef RESET_GUARD_PARAMS_SVH
`define RESET_GUARD_PARAMS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define ADDR_GUARD      32'h0000_0000
`define ADDR_CAUSE      32'h0000_0004
`define ADDR_THRESH     32'h0000_0008
`define ADDR_FILTER     32'h0000_000C

// Pin-function guard codes and power-on value.
`define GUARD_POR       8'h55
`define GUARD_IO        8'h55
`define GUARD_RST       8'hAA

// Brownout threshold codes and power-on value.
`define THR_POR         8'h66
`define THR_1V7         8'h66
`define THR_1V9         8'h55
`define THR_2V55        8'h33
`define THR_3V15        8'h99
`define THR_3V8         8'hAA
`define THR_OFF         8'hF0

// Filter width field power-on value and lengths in slow oscillator ticks.
`define FILT_POR        2'h1
`define FILT_LEN_0      8'h08
`define FILT_LEN_1      8'h20
`define FILT_LEN_2      8'h40
`define FILT_LEN_3      8'h80

// Watchdog enable field codes.
`define WDT_DIS         5'h15
`define WDT_EN          5'h0A

// Bit positions in the reset-cause register.
`define CAUSE_GUARD     3
`define CAUSE_BO        2
`define CAUSE_THR       1
`define CAUSE_WDT       0

// Soft-fault delay in slow oscillator ticks.
`define SOFT_CNT_W      16
`define SOFT_FAULT_TICKS 16'h0010

// AXI responses.
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ### reset_guard_pkg.sv
package reset_guard_pkg;
`include "reset_guard_params.svh"

    typedef enum logic [1:0] {
        F_IDLE  = 2'h0,
        F_COUNT = 2'h1,
        F_FIRE  = 2'h3
    } fault_st_t;

    typedef enum logic [1:0] {
        PIN_ALWAYS_IO  = 2'h0,
        PIN_ALWAYS_RST = 2'h1,
        PIN_BY_REG     = 2'h2
    } pin_opt_t;

    typedef enum logic [2:0] {
        BO_NONE = 3'h0,
        BO_1V7  = 3'h1,
        BO_1V9  = 3'h2,
        BO_2V55 = 3'h3,
        BO_3V15 = 3'h4,
        BO_3V8  = 3'h5
    } bo_level_t;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;

    typedef struct packed {
        logic [7:0]             guard;
        logic [7:0]             thr;
        logic [1:0]             filt;
        logic [3:0]             cause;
        fault_st_t              fst;
        logic [3:0]             fsrc;
        logic [`SOFT_CNT_W-1:0] fcnt;
        logic [7:0]             bcnt;
        logic                   rst_out;
        logic                   aw_have;
        logic [31:0]            aw_addr;
        logic                   w_have;
        logic [7:0]             w_data;
        logic                   w_en;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [7:0]             rdata;
        logic [1:0]             rresp;
        logic                   rd_cause;
    } state_t;
endpackage

// ### reset_guard_brownout_ctrl.sv
// Notes on behaviour
// - Always-reset option: valid codes keep reset pin.
// - Always-I/O option: valid codes keep general I/O.
// - Register option: 55h I/O, AAh reset, else reset; the code gives I/O for other codes.
// - Bad guard code: delayed reset, set guard flag.
// - Every reset reloads guard to 55h, brownout too.
// - Reset pin selection overrides other pin sharing.
// - Guard flag bit 3, software clears by zero.
// - Cause register upper four bits read zero.
// - Enabled monitor runs in run modes, resets.
// - Undervolt shorter than filter width is ignored.
// - Filter code picks 8/32/64/128 slow ticks.
// - Threshold code decodes five levels or off.
// - Bad threshold code: delayed reset, flag, reload.
// - Brownout reset keeps threshold register contents.
// - Sleep or idle disables the brownout monitor.
// - Brownout flag bit 2, software clears by zero.
// - Threshold fault flag bit 1, software clears.
// - Watchdog fault flag bit 0, software clears.
// - Filter register bits 7..2 zero, powers up 01.
// - Watchdog code 15h off, 0Ah on, else reset.
`timescale 1ns/1ps
`include "reset_guard_params.svh"
module reset_guard_brownout_ctrl
    import reset_guard_pkg::*;
#(
    parameter logic [`SOFT_CNT_W-1:0] SOFT_FAULT_TICKS = `SOFT_FAULT_TICKS
) (
    // Clock and reset.
    input  wire logic      clk,
    input  wire logic      sys_rst,
    // Register bus.
    input  wire axil_req_t axi_req,
    output axil_rsp_t      axi_rsp,
    // Straps and mode inputs.
    input  wire pin_opt_t  pin_option,
    input  wire logic      run_mode,
    input  wire logic      low_power,
    input  wire logic [4:0] watchdog_enable_code,
    input  wire logic      other_reset,
    // Slow oscillator tick and analog monitor.
    input  wire logic      slow_osc_tick,
    input  wire logic      undervolt,
    // Shared pin.
    input  wire logic      external_clear_pin_n,
    output logic           pin_reset_sel,
    output logic           pin_io_sel,
    // Reset and monitor control outputs.
    output logic           chip_reset,
    output logic           bo_enable,
    output bo_level_t      bo_level
);

    state_t st_ff;
    state_t nxt_st;

    function automatic bo_level_t thr_decode(input logic [7:0] code);
        unique case (code)
            `THR_1V7:  thr_decode = BO_1V7;
            `THR_1V9:  thr_decode = BO_1V9;
            `THR_2V55: thr_decode = BO_2V55;
            `THR_3V15: thr_decode = BO_3V15;
            `THR_3V8:  thr_decode = BO_3V8;
            default:   thr_decode = BO_NONE;
        endcase
    endfunction

    function automatic logic thr_valid(input logic [7:0] code);
        thr_valid = (thr_decode(code) != BO_NONE) || (code == `THR_OFF);
    endfunction

    function automatic logic [7:0] filt_last(input logic [1:0] code);
        unique case (code)
            2'h0:    filt_last = `FILT_LEN_0 - 8'h01;
            2'h1:    filt_last = `FILT_LEN_1 - 8'h01;
            2'h2:    filt_last = `FILT_LEN_2 - 8'h01;
            default: filt_last = `FILT_LEN_3 - 8'h01;
        endcase
    endfunction

    logic       guard_ok;
    logic [3:0] fault_now;
    logic       bo_fire;
    logic       ext_fire;
    logic       fault_fire;

    assign guard_ok = (st_ff.guard == `GUARD_IO) || (st_ff.guard == `GUARD_RST);

    // The strap value 3 is not a legal option; it behaves as register control.
    always_comb begin
        unique case (pin_option)
            PIN_ALWAYS_IO:  pin_reset_sel = 1'b0;
            PIN_ALWAYS_RST: pin_reset_sel = 1'b1;
            default:        pin_reset_sel = (st_ff.guard == `GUARD_RST);
        endcase
    end
    // Reset selection masks every other sharing control of the pin.
    assign pin_io_sel = !pin_reset_sel;

    always_comb begin
        fault_now = 4'h0;
        fault_now[`CAUSE_GUARD] = !guard_ok;
        fault_now[`CAUSE_THR]   = !thr_valid(st_ff.thr);
        fault_now[`CAUSE_WDT]   = (watchdog_enable_code != `WDT_DIS) &&
                                  (watchdog_enable_code != `WDT_EN);
    end

    assign bo_level  = thr_decode(st_ff.thr);
    assign bo_enable = run_mode && !low_power && (bo_level != BO_NONE);
    // Ticks are counted only while the low supply persists, so a short dip restarts the filter.
    assign bo_fire   = bo_enable && undervolt && slow_osc_tick &&
                       (st_ff.bcnt == filt_last(st_ff.filt));
    assign ext_fire   = pin_reset_sel && !external_clear_pin_n;
    assign fault_fire = (st_ff.fst == F_FIRE);

    always_comb begin
        logic [3:0] set_flags;
        set_flags = 4'h0;
        nxt_st = st_ff;
        nxt_st.rst_out = 1'b0;

        // Write channel: address and data are taken independently.
        if (axi_req.awvalid && axi_rsp.awready) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready) begin
            nxt_st.w_have = 1'b1;
            nxt_st.w_data = axi_req.wdata[7:0];
            nxt_st.w_en   = axi_req.wstrb[0];
        end
        if (st_ff.bvalid && axi_req.bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.aw_have && st_ff.w_have) begin
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = `RESP_OKAY;
            if (st_ff.aw_addr == `ADDR_GUARD) begin
                if (st_ff.w_en) begin
                    nxt_st.guard = st_ff.w_data;
                end
            end else if (st_ff.aw_addr == `ADDR_THRESH) begin
                if (st_ff.w_en) begin
                    nxt_st.thr = st_ff.w_data;
                end
            end else if (st_ff.aw_addr == `ADDR_FILTER) begin
                if (st_ff.w_en) begin
                    nxt_st.filt = st_ff.w_data[1:0];
                end
            end else if (st_ff.aw_addr == `ADDR_CAUSE) begin
                if (st_ff.w_en) begin
                    nxt_st.cause = st_ff.cause & st_ff.w_data[3:0];
                end
            end else begin
                nxt_st.bresp = `RESP_SLVERR;
            end
        end

        // Read channel: data is captured on the address handshake.
        if (st_ff.rvalid && axi_req.rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (axi_req.arvalid && axi_rsp.arready) begin
            nxt_st.rvalid   = 1'b1;
            nxt_st.rresp    = `RESP_OKAY;
            nxt_st.rd_cause = 1'b0;
            if (axi_req.araddr == `ADDR_GUARD) begin
                nxt_st.rdata = st_ff.guard;
            end else if (axi_req.araddr == `ADDR_THRESH) begin
                nxt_st.rdata = st_ff.thr;
            end else if (axi_req.araddr == `ADDR_FILTER) begin
                nxt_st.rdata = {6'h00, st_ff.filt};
            end else if (axi_req.araddr == `ADDR_CAUSE) begin
                nxt_st.rdata    = {4'h0, st_ff.cause};
                nxt_st.rd_cause = 1'b1;
            end else begin
                nxt_st.rdata = 8'h00;
                nxt_st.rresp = `RESP_SLVERR;
            end
        end

        // Soft-fault delay. Once started it runs to the end even if the code is repaired,
        // because a corrupted code may have already taken effect elsewhere.
        unique case (st_ff.fst)
            F_IDLE: begin
                if (fault_now != 4'h0) begin
                    nxt_st.fst  = F_COUNT;
                    nxt_st.fcnt = '0;
                    nxt_st.fsrc = fault_now;
                end
            end
            F_COUNT: begin
                nxt_st.fsrc = st_ff.fsrc | fault_now;
                if (slow_osc_tick) begin
                    if (st_ff.fcnt >= SOFT_FAULT_TICKS - `SOFT_CNT_W'(1)) begin
                        nxt_st.fst = F_FIRE;
                    end else begin
                        nxt_st.fcnt = st_ff.fcnt + `SOFT_CNT_W'(1);
                    end
                end
            end
            F_FIRE: begin
                nxt_st.fst = F_IDLE;
                set_flags  = set_flags | st_ff.fsrc;
            end
            default: nxt_st.fst = F_IDLE;
        endcase

        // Brownout filter counts slow ticks of a continuous undervoltage.
        if (bo_enable && undervolt) begin
            if (slow_osc_tick) begin
                nxt_st.bcnt = bo_fire ? 8'h00 : st_ff.bcnt + 8'h01;
            end
        end else begin
            nxt_st.bcnt = 8'h00;
        end
        if (bo_fire) begin
            set_flags[`CAUSE_BO] = 1'b1;
        end

        // Chip resets reload the guard code, and the threshold except on brownout; a software write in the same cycle loses.
        if (fault_fire || bo_fire || ext_fire || other_reset) begin
            nxt_st.guard = `GUARD_POR;
            if (fault_fire || ext_fire || other_reset) begin
                nxt_st.thr = `THR_POR;
            end
        end
        nxt_st.rst_out = fault_fire || bo_fire || ext_fire;

        // A flag set by hardware wins over a software clear in the same cycle.
        nxt_st.cause = nxt_st.cause | set_flags;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_ff       <= '0;
            st_ff.guard <= `GUARD_POR;
            st_ff.thr   <= `THR_POR;
            st_ff.filt  <= `FILT_POR;
            st_ff.fst   <= F_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        axi_rsp.awready = !st_ff.aw_have && !st_ff.bvalid;
        axi_rsp.wready  = !st_ff.w_have && !st_ff.bvalid;
        axi_rsp.bvalid  = st_ff.bvalid;
        axi_rsp.bresp   = st_ff.bresp;
        axi_rsp.arready = !st_ff.rvalid;
        axi_rsp.rvalid  = st_ff.rvalid;
        axi_rsp.rdata   = {24'h00_0000, st_ff.rdata};
        axi_rsp.rresp   = st_ff.rresp;
    end
    assign chip_reset = st_ff.rst_out;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_guard_fault_start: assert property (
        (st_ff.fst == F_IDLE) && !guard_ok |=> (st_ff.fst == F_COUNT))
        else $error("guard fault did not start the delay");
    a_guard_flag_set: assert property (
        fault_fire && st_ff.fsrc[`CAUSE_GUARD] |=> st_ff.cause[`CAUSE_GUARD] && chip_reset)
        else $error("guard fault reset lost its flag");
    a_reset_reload: assert property (
        chip_reset |-> (st_ff.guard == `GUARD_POR))
        else $error("guard not reloaded on reset");
    a_pin_by_reg: assert property (
        (pin_option == PIN_BY_REG) |-> (pin_reset_sel == (st_ff.guard == `GUARD_RST)))
        else $error("register pin selection wrong");
    a_pin_priority: assert property (
        pin_reset_sel |-> !pin_io_sel)
        else $error("pin shared while reset selected");
    a_cause_high_zero: assert property (
        axi_rsp.rvalid && st_ff.rd_cause |-> (axi_rsp.rdata[31:4] == 28'h000_0000))
        else $error("cause upper bits not zero");
    a_filter_length: assert property (
        $rose(st_ff.cause[`CAUSE_BO]) && !$past(st_ff.aw_have)
        |-> $past(st_ff.bcnt) == filt_last($past(st_ff.filt)))
        else $error("brownout fired before filter width");
    a_sleep_off: assert property (
        low_power |-> !bo_enable ##1 (!low_power || st_ff.bcnt == 8'h00))
        else $error("monitor active in low power");
    a_thr_kept: assert property (
        bo_fire && !fault_fire && !ext_fire && !other_reset && !(st_ff.aw_have && st_ff.w_have)
        |=> $stable(st_ff.thr))
        else $error("threshold changed by brownout reset");
    a_thr_restore: assert property (
        fault_fire && st_ff.fsrc[`CAUSE_THR] |=> (st_ff.thr == `THR_POR)
        && st_ff.cause[`CAUSE_THR])
        else $error("threshold fault not handled");
    a_wdt_flag_cause: assert property (
        $rose(st_ff.cause[`CAUSE_WDT]) |-> $past(st_ff.fst) == F_FIRE)
        else $error("watchdog flag set without fault reset");
    a_fault_delay: assert property (
        (st_ff.fst == F_COUNT) && !slow_osc_tick |=> (st_ff.fst == F_COUNT))
        else $error("fault fired without slow tick");

    c_guard_fault: cover property (fault_fire && st_ff.fsrc[`CAUSE_GUARD]);
    c_brownout: cover property (bo_fire);
    c_ext_pin: cover property (ext_fire);
    c_flag_clear: cover property ($fell(st_ff.cause[`CAUSE_BO]));

endmodule

// ### reset_guard_brownout_ctrl_tb.sv
`timescale 1ns/1ps
`include "reset_guard_params.svh"
module reset_guard_brownout_ctrl_tb
    import reset_guard_pkg::*;
();
    localparam int        FLEN [4] = '{8, 32, 64, 128};
    localparam logic [7:0] THR [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};
    localparam bo_level_t LV [6]   = '{BO_1V7, BO_1V9, BO_2V55, BO_3V15, BO_3V8, BO_NONE};
    logic        clk, sys_rst, run_mode, low_power, other_reset;
    axil_req_t   axi_req;
    axil_rsp_t   axi_rsp;
    pin_opt_t    pin_option;
    logic [4:0]  wdt_code;
    logic        slow_osc_tick, undervolt, ext_pin_n;
    logic        pin_reset_sel, pin_io_sel, chip_reset, bo_enable;
    bo_level_t   bo_level;
    logic [1:0]  tick_div;
    logic [7:0]  rnd;
    logic [31:0] exp_q[$];
    int          n_errors, checked, n_resets, r0;

    // A short fault delay keeps the run brief; all waits allow for it.
    reset_guard_brownout_ctrl #(.SOFT_FAULT_TICKS(16'h0002)) reset_guard_brownout_ctrl_inst (
        .clk(clk), .sys_rst(sys_rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .pin_option(pin_option), .run_mode(run_mode), .low_power(low_power),
        .watchdog_enable_code(wdt_code), .other_reset(other_reset),
        .slow_osc_tick(slow_osc_tick), .undervolt(undervolt),
        .external_clear_pin_n(ext_pin_n), .pin_reset_sel(pin_reset_sel),
        .pin_io_sel(pin_io_sel), .chip_reset(chip_reset), .bo_enable(bo_enable),
        .bo_level(bo_level));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        tick_div <= tick_div + 2'h1;
        slow_osc_tick <= (tick_div == 2'h3);
        if (chip_reset === 1'b1) n_resets++;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Read data is judged here, at the sample before the handshake edge.
    always @(negedge clk) begin
        if (sys_rst === 1'b0 && axi_rsp.rvalid === 1'b1 && axi_req.rready === 1'b1) begin
            if (exp_q.size() == 0) check(axi_rsp.rdata, 32'hDEAD_BEEF);
            else check(axi_rsp.rdata, exp_q.pop_front());
        end
    end

    task automatic clkn(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            while (slow_osc_tick !== 1'b1) @(posedge clk);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] rsp = 2'h0);
        int n;
        logic ah, wh, bh;
        @(posedge clk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= {24'h00_0000, d};
        axi_req.bready <= 1'b1;
        bh = 1'b0;
        n = 0;
        while (!bh && n < 100) begin
            @(negedge clk);
            ah = axi_req.awvalid && axi_rsp.awready;
            wh = axi_req.wvalid && axi_rsp.wready;
            bh = (axi_rsp.bvalid === 1'b1);
            if (bh) check({30'h0, axi_rsp.bresp}, {30'h0, rsp});
            @(posedge clk);
            if (ah) axi_req.awvalid <= 1'b0;
            if (wh) axi_req.wvalid <= 1'b0;
            if (bh) axi_req.bready <= 1'b0;
            n++;
        end
        if (!bh) n_errors++;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        int n;
        logic ah, rh;
        @(posedge clk);
        exp_q.push_back(e);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        rh = 1'b0;
        n = 0;
        while (!rh && n < 100) begin
            @(negedge clk);
            ah = axi_req.arvalid && axi_rsp.arready;
            rh = (axi_rsp.rvalid === 1'b1);
            @(posedge clk);
            if (ah) axi_req.arvalid <= 1'b0;
            if (rh) axi_req.rready <= 1'b0;
            n++;
        end
        if (!rh) n_errors++;
    endtask

    // Writing ones must leave a set flag alone, only a zero clears it.
    task automatic fault_end(input int b);
        clkn(40);
        check(n_resets, r0 + 1);
        rd(`ADDR_CAUSE, 32'h1 << b);
        wr(`ADDR_CAUSE, 8'hFF);
        rd(`ADDR_CAUSE, 32'h1 << b);
        wr(`ADDR_CAUSE, 8'h00);
        rd(`ADDR_CAUSE, 32'h0);
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        n_errors++;
        $display("wrong value at %0t: run did not finish", $time);
        complete_run();
    end

    initial begin
        sys_rst = 1'b1;
        axi_req = '0;
        axi_req.wstrb = 4'hF;
        pin_option = PIN_BY_REG;
        run_mode = 1'b1;
        low_power = 1'b0;
        wdt_code = `WDT_DIS;
        other_reset = 1'b0;
        undervolt = 1'b0;
        ext_pin_n = 1'b1;
        tick_div = 2'h0;
        slow_osc_tick = 1'b0;
        rnd = 8'h1C;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`ADDR_GUARD, 32'h55);
        rd(`ADDR_CAUSE, 32'h0);
        rd(`ADDR_THRESH, 32'h66);
        rd(`ADDR_FILTER, 32'h1);
        rd(32'h0000_0010, 32'h0);
        wr(32'h0000_0010, 8'h5A, 2'h2);
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            wr(`ADDR_FILTER, rnd);
            rd(`ADDR_FILTER, {30'h0, rnd[1:0]});
        end
        done("registers");
        for (int o = 0; o < 3; o++) begin
            for (int g = 0; g < 2; g++) begin
                wr(`ADDR_GUARD, g ? `GUARD_RST : `GUARD_IO);
                pin_option <= pin_opt_t'(o);
                clkn(2);
                check({31'h0, pin_reset_sel}, {31'h0, o == 1 || (o == 2 && g == 1)});
                check({31'h0, pin_io_sel}, {31'h0, !(o == 1 || (o == 2 && g == 1))});
            end
        end
        pin_option <= PIN_ALWAYS_RST;
        r0 = n_resets;
        ext_pin_n <= 1'b0;
        clkn(3);
        ext_pin_n <= 1'b1;
        clkn(4);
        check(n_resets, r0 + 3);
        pin_option <= PIN_BY_REG;
        wr(`ADDR_GUARD, `GUARD_RST);
        wr(`ADDR_THRESH, `THR_2V55);
        other_reset <= 1'b1;
        clkn(1);
        other_reset <= 1'b0;
        rd(`ADDR_GUARD, 32'h55);
        rd(`ADDR_THRESH, 32'h66);
        done("pin");
        for (int i = 0; i < 6; i++) begin
            wr(`ADDR_THRESH, THR[i]);
            clkn(2);
            check({29'h0, bo_level}, {29'h0, LV[i]});
            check({31'h0, bo_enable}, {31'h0, i != 5});
        end
        wr(`ADDR_THRESH, `THR_3V15);
        low_power <= 1'b1;
        clkn(2);
        check({31'h0, bo_enable}, 32'h0);
        low_power <= 1'b0;
        done("threshold");
        // Each width is tried one tick short and then exactly long enough.
        for (int i = 0; i < 4; i++) begin
            wr(`ADDR_FILTER, i[7:0]);
            for (int k = 0; k < 2; k++) begin
                r0 = n_resets;
                @(posedge clk);
                undervolt <= 1'b1;
                ticks(FLEN[i] - 1 + k);
                clkn(2);
                undervolt <= 1'b0;
                clkn(4);
                check(n_resets, r0 + k);
            end
            rd(`ADDR_CAUSE, 32'h4);
            rd(`ADDR_THRESH, 32'h99);
            wr(`ADDR_CAUSE, 8'h00);
        end
        done("brownout");
        r0 = n_resets;
        wr(`ADDR_GUARD, 8'h12);
        fault_end(3);
        rd(`ADDR_GUARD, 32'h55);
        r0 = n_resets;
        wr(`ADDR_THRESH, 8'h12);
        fault_end(1);
        rd(`ADDR_THRESH, 32'h66);
        @(posedge clk);
        r0 = n_resets;
        wdt_code <= 5'h03;
        clkn(1);
        wdt_code <= `WDT_EN;
        fault_end(0);
        clkn(40);
        check(n_resets, r0 + 1);
        done("faults");
        complete_run();
    end
endmodule
